// ===== rtl/ccd_digitiser_control_regs.sv
// Control register bank of a two-channel sensor digitiser with serial access.
// Assumes the host holds the serial clock still while it pulses the commit strobe.
`include "ccd_ctrl_defs.svh"

module ccd_digitiser_control_regs (
  // System clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Serial control link
  input  wire logic        serial_clk,
  input  wire logic        serial_in_line,
  input  wire logic        serial_commit_strobe,
  output logic             serial_out_line,
  output logic             serial_out_oe,
  // Setup one fields
  output logic             global_enable,
  output logic             double_sample_select,
  output logic             dual_channel_select,
  output logic             single_channel_select,
  output logic [1:0]       gain_stage_offset_code,
  // Setup two fields
  output logic [1:0]       output_latency_select,
  output logic             clamp_dac_range,
  output logic             reduced_reference_range,
  output logic             output_disable,
  output logic             output_polarity_invert,
  // Setup three fields
  output logic             single_input_select,
  output logic [1:0]       sampling_reference_select,
  output logic [3:0]       clamp_level_code,
  // Power-down and clamp fields
  output logic             aux_ref_powerdown,
  output logic             converter_ref_powerdown,
  output logic             clamp_dac_powerdown,
  output logic             converter_powerdown,
  output logic             clamp_timing_control,
  output logic             level_clamp_enable,
  // Effective channel power and zero-input code
  output logic             odd_path_active,
  output logic             even_path_active,
  output logic [9:0]       zero_input_code,
  // Channel offset and gain codes
  output logic [7:0]       odd_offset_code,
  output logic [7:0]       even_offset_code,
  output logic [8:0]       odd_gain_code,
  output logic [8:0]       even_gain_code
);

  // ----------------------------------------------------------------------
  // Link domain: shift in on rising edge, shift out on falling edge
  // ----------------------------------------------------------------------
  logic [13:0] link_shift_r;   // Last fourteen bits seen on the input
  logic [3:0]  link_cnt_r;     // Rising edges since the last commit
  logic        link_clr;       // Asynchronous clear of the bit counter and the read-back bit
  logic        sdo_r;          // Read-back bit on the shared pin
  ccd_ctrl_pkg::reg_byte_type rd_word_r;   // Read-back byte, sys domain

  // Commit strobe or reset restarts the frame; no sck edge is needed for it
  assign link_clr = serial_commit_strobe | ~rst_n;

  // Plain shift register: whatever sits here at commit is the word
  always_ff @(posedge serial_clk)
  begin
    link_shift_r <= {link_shift_r[12:0], serial_in_line};
  end

  // Bit counter, saturates once the word is complete
  always_ff @(posedge serial_clk or posedge link_clr)
  begin
    if (link_clr)
    begin
      link_cnt_r <= 4'h0;
    end
    else if (link_cnt_r != `FRAME_BITS)
    begin
      link_cnt_r <= link_cnt_r + 4'h1;
    end
  end

  // Read-back byte leaves MSB first on falling edges; rd_word_r is quasi-static,
  // it only changes just after a commit while the serial clock stands still
  always_ff @(negedge serial_clk or posedge link_clr)
  begin
    if (link_clr)
    begin
      sdo_r <= 1'b0;
    end
    else if (link_cnt_r != 4'h0 && link_cnt_r <= `DATA_BITS)
    begin
      sdo_r <= rd_word_r[3'(`DATA_BITS - link_cnt_r)];
    end
    else
    begin
      sdo_r <= 1'b0;
    end
  end

  assign serial_out_line = sdo_r;

  // ----------------------------------------------------------------------
  // Commit strobe synchroniser and word capture
  // ----------------------------------------------------------------------
  logic sen_s1_r;  // First stage, read only by the second
  logic sen_s2_r;  // Second stage
  logic sen_s3_r;  // Third stage
  logic sen_lvl_r; // Accepted strobe level, moves once stages agree
  logic commit;    // One cycle per strobe
  logic is_read;   // Address bit four set
  logic is_write;  // Address bit four clear
  ccd_ctrl_pkg::reg_addr_type addr;  // Target register, bit four cleared
  ccd_ctrl_pkg::reg_byte_type data;  // Written byte

  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sen_s1_r <= 1'b0;
      sen_s2_r <= 1'b0;
      sen_s3_r <= 1'b0;
      sen_lvl_r <= 1'b0;
    end
    else
    begin
      sen_s1_r <= serial_commit_strobe;
      sen_s2_r <= sen_s1_r;
      sen_s3_r <= sen_s2_r;
      sen_lvl_r <= (sen_s2_r == sen_s3_r) ? sen_s3_r : sen_lvl_r;
    end
  end

  // Word is stable here because the serial clock is idle around the strobe
  assign commit   = sen_s2_r & sen_s3_r & ~sen_lvl_r;
  assign is_read  = commit & link_shift_r[8 + `F_RW_BIT];
  assign is_write = commit & ~link_shift_r[8 + `F_RW_BIT];
  assign addr     = link_shift_r[13:8] & ~(6'h1 << `F_RW_BIT);
  assign data     = link_shift_r[7:0];

  // ----------------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------------
  ccd_ctrl_pkg::reg_byte_type setup1_r;   // Mode and enable
  ccd_ctrl_pkg::reg_byte_type setup2_r;   // Output and references
  ccd_ctrl_pkg::reg_byte_type setup3_r;   // Clamp and channel
  ccd_ctrl_pkg::reg_byte_type pwrdn_r;    // Block power-down bits
  ccd_ctrl_pkg::reg_byte_type clamp_r;    // Clamp control
  ccd_ctrl_pkg::reg_byte_type dac_odd_r;  // Odd offset DAC
  ccd_ctrl_pkg::reg_byte_type dac_even_r; // Even offset DAC
  ccd_ctrl_pkg::reg_byte_type ghi_odd_r;  // Odd gain bits 8:1
  ccd_ctrl_pkg::reg_byte_type ghi_even_r; // Even gain bits 8:1
  logic                       glo_odd_r;  // Odd gain bit 0
  logic                       glo_even_r; // Even gain bit 0
  logic                       bank_clear; // Reset or software reset

  // Software reset ignores the data byte entirely
  assign bank_clear = ~rst_n | (is_write & (addr == `A_SOFT_RST));

  // Setup registers; unused bits held at zero by masks
  always_ff @(posedge sys_clk)
  begin
    if (bank_clear)
    begin
      setup1_r <= `D_SETUP1;
      setup2_r <= `D_SETUP2;
      setup3_r <= `D_SETUP3;
      pwrdn_r  <= `D_PWRDN;
      clamp_r  <= `D_CLAMP;
    end
    else if (is_write)
    begin
      // Address decode
      if (addr == `A_SETUP1)
      begin
        setup1_r <= data & `M_SETUP1;
      end
      else if (addr == `A_SETUP2)
      begin
        setup2_r <= data & `M_SETUP2;
      end
      else if (addr == `A_SETUP3)
      begin
        setup3_r <= data & `M_SETUP3;
      end
      else if (addr == `A_PWRDN)
      begin
        pwrdn_r <= data & `M_PWRDN;
      end
      else if (addr == `A_CLAMP)
      begin
        clamp_r <= data & `M_CLAMP;
      end
    end
  end

  // Channel offset and gain registers; shared addresses load both
  always_ff @(posedge sys_clk)
  begin
    if (bank_clear)
    begin
      dac_odd_r  <= `D_DAC;
      dac_even_r <= `D_DAC;
      glo_odd_r  <= `D_GLO;
      glo_even_r <= `D_GLO;
      ghi_odd_r  <= `D_GHI;
      ghi_even_r <= `D_GHI;
    end
    else if (is_write)
    begin
      // Odd and even DACs
      if (addr == `A_DAC_ODD || addr == `A_DAC_BOTH)
      begin
        dac_odd_r <= data;
      end
      if (addr == `A_DAC_EVEN || addr == `A_DAC_BOTH)
      begin
        dac_even_r <= data;
      end
      // Gain low bits
      if (addr == `A_GLO_ODD || addr == `A_GLO_BOTH)
      begin
        glo_odd_r <= data[0];
      end
      if (addr == `A_GLO_EVEN || addr == `A_GLO_BOTH)
      begin
        glo_even_r <= data[0];
      end
      // Gain high bits
      if (addr == `A_GHI_ODD || addr == `A_GHI_BOTH)
      begin
        ghi_odd_r <= data;
      end
      if (addr == `A_GHI_EVEN || addr == `A_GHI_BOTH)
      begin
        ghi_even_r <= data;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read-back capture
  // ----------------------------------------------------------------------
  ccd_ctrl_pkg::reg_byte_type rd_mux;  // Addressed register content
  logic                       rd_active_r;  // Read-back owns the shared pin

  // Write-only, reserved and unlisted addresses all read as a fixed zero
  always_comb
  begin
    if (addr == `A_SETUP1)
      rd_mux = setup1_r;
    else if (addr == `A_SETUP2)
      rd_mux = setup2_r;
    else if (addr == `A_SETUP3)
      rd_mux = setup3_r;
    else if (addr == `A_PWRDN)
      rd_mux = pwrdn_r;
    else if (addr == `A_CLAMP)
      rd_mux = clamp_r;
    else if (addr == `A_DAC_ODD)
      rd_mux = dac_odd_r;
    else if (addr == `A_DAC_EVEN)
      rd_mux = dac_even_r;
    else if (addr == `A_GLO_ODD)
      rd_mux = {7'h0, glo_odd_r};
    else if (addr == `A_GLO_EVEN)
      rd_mux = {7'h0, glo_even_r};
    else if (addr == `A_GHI_ODD)
      rd_mux = ghi_odd_r;
    else if (addr == `A_GHI_EVEN)
      rd_mux = ghi_even_r;
    else
      rd_mux = `D_FIXED;
  end

  // Read has no side effect beyond loading the output byte and setting rd_active_r
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      rd_word_r   <= `D_FIXED;
      rd_active_r <= 1'b0;
    end
    else if (is_read)
    begin
      rd_word_r   <= rd_mux;
      rd_active_r <= 1'b1;
    end
    else if (is_write)
    begin
      rd_active_r <= 1'b0;
    end
  end

  // Pin driven only for read-back and only while outputs are not disabled
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      serial_out_oe <= 1'b0;
    else
      serial_out_oe <= rd_active_r & ~setup2_r[3];
  end

  // ----------------------------------------------------------------------
  // Field outputs, straight from the bank
  // ----------------------------------------------------------------------
  assign global_enable             = setup1_r[`F_EN];
  assign double_sample_select      = setup1_r[`F_CDS];
  assign dual_channel_select       = setup1_r[3];
  assign single_channel_select     = setup1_r[2];
  assign gain_stage_offset_code    = setup1_r[`F_GOFS];
  assign output_latency_select     = setup2_r[7:6];
  assign clamp_dac_range           = setup2_r[5];
  assign reduced_reference_range   = setup2_r[4];
  assign output_disable            = setup2_r[3];
  assign output_polarity_invert    = setup2_r[2];
  assign single_input_select       = setup3_r[`F_SINGLE_INPUT_SELECT];
  assign sampling_reference_select = setup3_r[5:4];
  assign clamp_level_code          = setup3_r[3:0];
  assign aux_ref_powerdown         = pwrdn_r[6];
  assign converter_ref_powerdown   = pwrdn_r[5];
  assign clamp_dac_powerdown       = pwrdn_r[4];
  assign converter_powerdown       = pwrdn_r[3];
  assign clamp_timing_control      = clamp_r[6];
  assign level_clamp_enable        = clamp_r[5];
  assign odd_offset_code           = dac_odd_r;
  assign even_offset_code          = dac_even_r;
  assign odd_gain_code             = {ghi_odd_r, glo_odd_r};
  assign even_gain_code            = {ghi_even_r, glo_even_r};

  // ----------------------------------------------------------------------
  // Derived state: channel power and zero-input code
  // ----------------------------------------------------------------------
  ccd_ctrl_pkg::single_input_select_mode_type chmode;  // Decoded channel mode
  assign chmode = ccd_ctrl_pkg::single_input_select_mode_type'(setup1_r[`F_CHMODE]);

  // Global enable overrides everything; mono mode powers the unused side down
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      odd_path_active  <= 1'b0;
      even_path_active <= 1'b0;
    end
    else if (!setup1_r[`F_EN])
    begin
      odd_path_active  <= 1'b0;
      even_path_active <= 1'b0;
    end
    else
    begin
      case (chmode)
        ccd_ctrl_pkg::CHMODE_DUAL:
        begin
          odd_path_active  <= ~pwrdn_r[`F_ODD_PATH_POWERDOWN];
          even_path_active <= ~pwrdn_r[`F_EVEN_PATH_POWERDOWN];
        end
        ccd_ctrl_pkg::CHMODE_MONO:
        begin
          odd_path_active  <= ~setup3_r[`F_SINGLE_INPUT_SELECT] & ~pwrdn_r[`F_ODD_PATH_POWERDOWN];
          even_path_active <= setup3_r[`F_SINGLE_INPUT_SELECT] & ~pwrdn_r[`F_EVEN_PATH_POWERDOWN];
        end
        // Off and invalid modes sample nothing
        default:
        begin
          odd_path_active  <= 1'b0;
          even_path_active <= 1'b0;
        end
      endcase
    end
  end

  // Code that a zero differential input produces
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      zero_input_code <= `CODE_MID;
    else if (!setup1_r[`F_GOFS_HI])
      zero_input_code <= `CODE_MID;
    else if (setup1_r[`F_GOFS] == `GOFS_POS)
      zero_input_code <= `CODE_FULL;
    else
      zero_input_code <= `CODE_ZERO;
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_write_at(logic [5:0] a);
    is_write && addr == a;
  endsequence

  property p_soft_reset;
    s_write_at(`A_SOFT_RST) |=> setup1_r == `D_SETUP1 && dac_odd_r == `D_DAC && ghi_even_r == `D_GHI;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset left a register changed");

  property p_setup1_write;
    s_write_at(`A_SETUP1) |=> setup1_r == ($past(data) & `M_SETUP1);
  endproperty
  a_setup1_write: assert property (p_setup1_write) else $error("setup one did not take the write");

  property p_dac_both;
    s_write_at(`A_DAC_BOTH) |=> dac_odd_r == $past(data) && dac_even_r == $past(data);
  endproperty
  a_dac_both: assert property (p_dac_both) else $error("shared offset did not load both");

  property p_gain_both;
    s_write_at(`A_GHI_BOTH) |=> odd_gain_code[8:1] == $past(data) && even_gain_code[8:1] == $past(data);
  endproperty
  a_gain_both: assert property (p_gain_both) else $error("shared gain did not load both");

  property p_zero_mid;
    !setup1_r[`F_GOFS_HI] ##1 !$past(setup1_r[`F_GOFS_HI]) |-> zero_input_code == `CODE_MID;
  endproperty
  a_zero_mid: assert property (p_zero_mid) else $error("zero code not mid-scale");

  property p_zero_full;
    setup1_r[`F_GOFS] == `GOFS_POS |=> zero_input_code == `CODE_FULL;
  endproperty
  a_zero_full: assert property (p_zero_full) else $error("zero code not full scale");

  property p_zero_neg;
    setup1_r[`F_GOFS] == `GOFS_NEG |=> zero_input_code == `CODE_ZERO;
  endproperty
  a_zero_neg: assert property (p_zero_neg) else $error("zero code not zero");

  property p_disabled;
    !global_enable |=> !odd_path_active && !even_path_active;
  endproperty
  a_disabled: assert property (p_disabled) else $error("path active while disabled");

  property p_mono;
    global_enable && chmode == ccd_ctrl_pkg::CHMODE_MONO |=> !(odd_path_active && even_path_active);
  endproperty
  a_mono: assert property (p_mono) else $error("both paths active in mono mode");

  property p_read_fixed;
    is_read && addr == `A_DAC_BOTH |=> rd_word_r == `D_FIXED && $stable(dac_odd_r);
  endproperty
  a_read_fixed: assert property (p_read_fixed) else $error("write-only read not fixed");

  property p_read_setup1;
    is_read && addr == `A_SETUP1 |=> rd_word_r == $past(setup1_r) ##1 serial_out_oe == !output_disable;
  endproperty
  a_read_setup1: assert property (p_read_setup1) else $error("read-back byte wrong");

endmodule : ccd_digitiser_control_regs

// ===== rtl/ccd_ctrl_defs.svh
// Constants of the digitiser control register bank: addresses, defaults, fields.
// Assumes inclusion by the bank module only; holds definitions and nothing else.
//
// Notes on behaviour
// - Six-bit address picks register; defaults after reset.
// - Setup one bit 0 enables whole device.
// - Bits 3:2 choose dual or single channel.
// - Offset upper bit clear gives zero code 511.
// - Offset field 10 gives zero code 1023.
// - Shared registers load both channels; write-only.
// - Nine-bit gain split across low, high registers.
// - Write: address a4 clear, data, then commit.
// - Read: a4 set, data out on falling edge.
// - Writing address four restores every default.
// - Offset field 11 gives zero code 0.
`ifndef CCD_CTRL_DEFS_SVH
`define CCD_CTRL_DEFS_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define A_SETUP1     6'h01
`define A_SETUP2     6'h02
`define A_SETUP3     6'h03
`define A_SOFT_RST   6'h04
`define A_RSV06      6'h06
`define A_PWRDN      6'h07
`define A_CLAMP      6'h08
`define A_RSV09      6'h09
`define A_RSV0C      6'h0c
`define A_DAC_ODD    6'h20
`define A_DAC_EVEN   6'h21
`define A_RSV22      6'h22
`define A_DAC_BOTH   6'h23
`define A_GLO_ODD    6'h24
`define A_GLO_EVEN   6'h25
`define A_RSV26      6'h26
`define A_GLO_BOTH   6'h27
`define A_GHI_ODD    6'h28
`define A_GHI_EVEN   6'h29
`define A_RSV2A      6'h2a
`define A_GHI_BOTH   6'h2b

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define D_SETUP1     8'h0b
`define D_SETUP2     8'h20
`define D_SETUP3     8'h1f
`define D_PWRDN      8'h00
`define D_CLAMP      8'h20
`define D_DAC        8'h80
`define D_GLO        1'h0
`define D_GHI        8'h0c
`define D_FIXED      8'h00

// ----------------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------------
`define F_RW_BIT     4
`define F_EN         0
`define F_CDS        1
`define F_CHMODE     3:2
`define F_GOFS       5:4
`define F_GOFS_HI    5
`define F_SINGLE_INPUT_SELECT       6
`define M_SETUP1     8'h3f
`define M_SETUP2     8'hfc
`define M_SETUP3     8'h7f
`define M_PWRDN      8'h7b
`define M_CLAMP      8'h60
`define F_ODD_PATH_POWERDOWN      0
`define F_EVEN_PATH_POWERDOWN     1

// ----------------------------------------------------------------------
// Zero-input output codes and serial framing
// ----------------------------------------------------------------------
`define CODE_MID     10'h1ff
`define CODE_FULL    10'h3ff
`define CODE_ZERO    10'h000
`define GOFS_POS     2'h2
`define GOFS_NEG     2'h3
`define FRAME_BITS   4'he
`define DATA_BITS    4'h8

`endif

// ===== rtl/ccd_ctrl_pkg.sv
// Types shared by the digitiser control register bank.
// Assumes the constants header carries every numeric value.
package ccd_ctrl_pkg;

  // One register byte and one register address
  typedef logic [7:0] reg_byte_type;
  typedef logic [5:0] reg_addr_type;

  // Channel mode field of setup one
  typedef enum logic [1:0] {
    CHMODE_OFF  = 2'h0,
    CHMODE_MONO = 2'h1,
    CHMODE_DUAL = 2'h2,
    CHMODE_BAD  = 2'h3
  } single_input_select_mode_type;

endpackage : ccd_ctrl_pkg

// ===== sim/serial_host_model.sv
// Host side of the serial control link: shifts words and pulses the commit strobe.
// Assumes the bench calls xfer one word at a time while sys_clk keeps running.
module serial_host_model (
  // System clock that times the commit strobe
  input  wire logic       sys_clk,
  // Serial link pins
  output logic            serial_clk,
  output logic            serial_in_line,
  output logic            serial_commit_strobe,
  input  wire logic       sdo_pin,
  // Captured read-back byte with a one-cycle valid
  output logic [7:0]      rd_byte,
  output logic            rd_valid
);
  timeunit 1ns;
  timeprecision 100ps;

  logic rd_pend;  // Previous word asked for read-back

  // Idle link: clock held low between frames
  initial
  begin
    serial_clk = 1'b0;
    serial_in_line = 1'b0;
    serial_commit_strobe = 1'b0;
    rd_byte = 8'h00;
    rd_valid = 1'b0;
    rd_pend = 1'b0;
  end

  // ----------------------------------------------------------------------
  // One fourteen-bit word, address then data, MSB first
  // ----------------------------------------------------------------------
  task automatic xfer(input logic [5:0] addr, input logic [7:0] data);
    logic [13:0] word;
    logic [7:0]  cap;
    word = {addr, data};
    cap = 8'h00;
    #13.7;  // Odd lead-in keeps link edges off the system clock grid
    for (int k = 13; k >= 0; k--)
    begin
      serial_in_line = word[k];
      #40 serial_clk = 1'b1;
      // Read-back bit was launched on the previous falling edge
      if (k <= 12 && k >= 5)
        cap = {cap[6:0], sdo_pin};
      #40 serial_clk = 1'b0;
    end
    serial_in_line = ~serial_in_line;  // Released line shows no stale bit
    // Strobe held long enough for the three-flop synchroniser
    @(negedge sys_clk) serial_commit_strobe = 1'b1;
    repeat (6) @(negedge sys_clk);
    serial_commit_strobe = 1'b0;
    repeat (8) @(negedge sys_clk);
    rd_byte = cap;
    rd_valid = rd_pend;
    rd_pend = addr[4];
    @(negedge sys_clk) rd_valid = 1'b0;
  endtask
endmodule // serial_host_model

// ===== sim/ccd_digitiser_control_regs_tb_top.sv
// Self-checking bench for the digitiser control register bank.
// Assumes the host model drives the link; sys_clk runs at 250 MHz.
module ccd_digitiser_control_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       serial_clk, serial_in_line, serial_commit_strobe, serial_out_line, serial_out_oe;
  logic       sdo_pin, rd_valid, global_enable, double_sample_select, dual_channel_select;
  logic       odd_path_active, even_path_active;
  logic [9:0] zero_input_code;
  logic [7:0] odd_offset_code, even_offset_code, rd_byte;
  logic [8:0] odd_gain_code, even_gain_code;
  int         num_errors = 0;
  int         checked = 0;
  int         seed = 55118;
  logic [7:0] exp_q[$];  // Expected read-back bytes, oldest first
  // Addresses read after reset and the bytes they must return
  logic [5:0] def_a [24] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0a, 6'h0b,
    6'h0c, 6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27, 6'h28, 6'h29, 6'h2a, 6'h2b};
  logic [7:0] def_v [24] = '{8'h0b, 8'h20, 8'h1f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0c, 8'h0c, 8'h00, 8'h00};
  // Writable registers and the bits they keep
  logic [5:0] rw_a [11] = '{6'h01, 6'h02, 6'h03, 6'h07, 6'h08, 6'h20, 6'h21, 6'h24, 6'h25, 6'h28, 6'h29};
  logic [7:0] rw_m [11] = '{8'h3f, 8'hfc, 8'h7f, 8'h7b, 8'h60, 8'hff, 8'hff, 8'h01, 8'h01, 8'hff, 8'hff};

  always #2 sys_clk = ~sys_clk;
  // Undriven shared pin shows the inverse, never a stale bit
  assign sdo_pin = serial_out_oe ? serial_out_line : ~serial_out_line;

  // ----------------------------------------------------------------------
  // Design and host model
  // ----------------------------------------------------------------------
  ccd_digitiser_control_regs i_ccd_digitiser_control_regs (
    .sys_clk(sys_clk), .rst_n(rst_n), .serial_clk(serial_clk), .serial_in_line(serial_in_line),
    .serial_commit_strobe(serial_commit_strobe), .serial_out_line(serial_out_line),
    .serial_out_oe(serial_out_oe), .global_enable(global_enable), .double_sample_select(double_sample_select),
    .dual_channel_select(dual_channel_select), .single_channel_select(), .gain_stage_offset_code(),
    .output_latency_select(), .clamp_dac_range(), .reduced_reference_range(), .output_disable(),
    .output_polarity_invert(), .single_input_select(), .sampling_reference_select(), .clamp_level_code(),
    .aux_ref_powerdown(), .converter_ref_powerdown(), .clamp_dac_powerdown(), .converter_powerdown(),
    .clamp_timing_control(), .level_clamp_enable(), .odd_path_active(odd_path_active),
    .even_path_active(even_path_active), .zero_input_code(zero_input_code), .odd_offset_code(odd_offset_code),
    .even_offset_code(even_offset_code), .odd_gain_code(odd_gain_code), .even_gain_code(even_gain_code));

  serial_host_model i_serial_host_model (
    .sys_clk(sys_clk), .serial_clk(serial_clk), .serial_in_line(serial_in_line),
    .serial_commit_strobe(serial_commit_strobe), .sdo_pin(sdo_pin), .rd_byte(rd_byte), .rd_valid(rd_valid));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    i_serial_host_model.xfer(a, d);
  endtask

  // Read request with random dummy data; byte arrives next frame
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_serial_host_model.xfer(a | 6'h10, 8'($random(seed)));
  endtask

  task automatic chk_defaults;
    chk("odd_gain", 10'h018, 10'(odd_gain_code));
    chk("even_gain", 10'h018, 10'(even_gain_code));
    chk("even_offset", 10'h080, 10'(even_offset_code));
    chk("sampling", 10'h001, 10'(double_sample_select));
    chk("enable", 10'h001, 10'(global_enable));
    chk("zero_code", 10'h1ff, zero_input_code);
    chk("odd_active", 10'h001, 10'(odd_path_active));
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Monitor: each captured read-back byte meets the oldest note
  always @(posedge sys_clk)
    if (rd_valid === 1'b1)
      chk("read_back", 10'(exp_q.pop_front()), 10'(rd_byte));

  // Watchdog sized at nearly three times the expected run
  initial
  begin
    #300000;
    num_errors++;
    give_verdict();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    logic [7:0] v;
    logic [7:0] g;
    logic [7:0] wv [11];
    logic [1:0] md;
    logic [1:0] gofs;
    logic       ch;
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk_defaults();
    wr(6'h06, 8'hff);  // Reserved place ignores the write
    foreach (def_a[i])
    begin
      rd(def_a[i], def_v[i]);
      if (i == 0) chk("out_oe", 10'h001, 10'(serial_out_oe));
    end
    $display("test defaults done");
    foreach (rw_a[i])
    begin
      v = 8'($random(seed));
      if (rw_a[i] == 6'h02) v[3] = 1'b0;  // Keep the read-back pin driven
      wv[i] = v;
      wr(rw_a[i], v);
      rd(rw_a[i], v & rw_m[i]);
    end
    chk("odd_gain", 10'({wv[9], wv[7][0]}), 10'(odd_gain_code));
    chk("even_gain", 10'({wv[10], wv[8][0]}), 10'(even_gain_code));
    chk("odd_offset", 10'(wv[5]), 10'(odd_offset_code));
    $display("test read_write done");
    v = 8'($random(seed));
    g = 8'($random(seed));
    wr(6'h23, v);
    chk("odd_offset", 10'(v), 10'(odd_offset_code));
    chk("even_offset", 10'(v), 10'(even_offset_code));
    wr(6'h27, v);
    wr(6'h2b, g);
    chk("odd_gain", 10'({g, v[0]}), 10'(odd_gain_code));
    chk("even_gain", 10'({g, v[0]}), 10'(even_gain_code));
    rd(6'h2b, 8'h00);
    $display("test shared done");
    wr(6'h04, 8'($random(seed)));
    chk_defaults();
    rd(6'h02, 8'h20);
    $display("test soft_reset done");
    for (int i = 0; i < 32; i++)
    begin
      {ch, gofs, md} = 5'(i);
      if (i % 16 == 0) wr(6'h03, {1'b0, ch, 6'h1f});
      wr(6'h01, {2'h0, gofs, md, 2'h3});
      chk("zero_code", gofs == 2'h2 ? 10'h3ff : gofs == 2'h3 ? 10'h000 : 10'h1ff, zero_input_code);
      chk("odd_active", 10'(md == 2'h2 || (md == 2'h1 && !ch)), 10'(odd_path_active));
      chk("even_active", 10'(md == 2'h2 || (md == 2'h1 && ch)), 10'(even_path_active));
      chk("dual_sel", 10'(md[1]), 10'(dual_channel_select));
    end
    $display("test modes done");
    wr(6'h01, 8'h0a);
    chk("enable", 10'h000, 10'(global_enable));
    chk("odd_active", 10'h000, 10'(odd_path_active));
    chk("sampling", 10'h001, 10'(double_sample_select));
    wr(6'h01, 8'h09);
    chk("enable", 10'h001, 10'(global_enable));
    chk("sampling", 10'h000, 10'(double_sample_select));
    rd(6'h01, 8'h09);
    wr(6'h06, 8'h00);  // Flush the last read-back
    repeat (4) @(negedge sys_clk);
    chk("pending_reads", 10'h000, 10'(exp_q.size()));
    $display("test enable done");
    give_verdict();
  end
endmodule // ccd_digitiser_control_regs_tb_top
